// File: rtl/pmc_power_mode_controller.sv
// Power-mode sequencer: Run, Sleep, Stop and Standby, with clock gating,
// transceiver power, retention, pin state and wakeup qualification.
// Assumes software strobes and peripheral interrupts are on clk; the RTC
// event and all pins are asynchronous and are synchronised here.
`timescale 1ns/100ps

// Functional notes
// - Reset always lands in Run, core clocked.
// - Low-power entry only on software request.
// - Run: clock only enabled or stack peripherals.
// - Run: transceiver on unless software disables.
// - Sleep: core stopped, wake sources stay clocked.
// - Sleep: any selected interrupt wakes within 1.8us.
// - Sleep: pin configuration left unchanged.
// - Stop: core and peripherals unclocked, context kept.
// - Stop: RTC or pin interrupt wakes, 5.4us.
// - Stop: pins hold configuration from entry.
// - Standby: transceiver, peripherals off, context lost.
// - Backup registers kept in every mode.
// - Standby: RTC or wakeup pin, 50us.
// - Standby: all pins become analog inputs.
// - Standby exit runs full reset sequence.
// - External reset pin is debounced first.
// - Core clock 8MHz after reset, selectable later.
// - Boot select high at reset starts bootloader.
module pmc_power_mode_controller
   import pmc_pkg::*;
#(
   parameter int SBY_CYC = SBY_LAT_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reset_n_pin,
   input wire logic boot_select_pin,
   input wire pmc_sw_t sw,
   input wire logic [NPER-1:0] periph_en,
   input wire logic [NPER-1:0] stack_use,
   input wire logic [NPER-1:0] wake_sel,
   input wire logic [NPER-1:0] periph_irq,
   input wire pmc_wake_t wake_cfg,
   input wire logic trx_irq,
   input wire logic rtc_evt,
   input wire logic ext_irq_pin,
   input wire logic wakeup_pin,
   output pmc_mode_t mode_q,
   output logic core_rst_q,
   output logic core_clk_en_q,
   output pmc_clk_t core_clk_sel_q,
   output logic [NPER-1:0] periph_clk_en_q,
   output logic radio_transceiver_pwr_q,
   output logic ctx_retain_q,
   output logic io_hold_q,
   output logic io_analog_q,
   output logic backup_keep_q,
   output logic main_supply_off_ok_q,
   output logic bootloader_q
);

   // ------------------------------------------------------------------
   // Synchronisers and reset debounce
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {S_BOOT, S_RUN, S_SLEEP, S_STOP, S_STANDBY, S_WAKE} pmc_st_t;

   logic [3:0] as1_q;
   logic [3:0] as2_q;
   logic rtc_s;
   logic ext_s;
   logic pin_s;
   logic boot_s;
   logic btn_n;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         as1_q <= '0;
         as2_q <= '0;
      end else begin
         as1_q <= {boot_select_pin, wakeup_pin, ext_irq_pin, rtc_evt};
         as2_q <= as1_q;
      end
   end

   assign rtc_s = as2_q[0];
   assign ext_s = as2_q[1];
   assign pin_s = as2_q[2];
   assign boot_s = as2_q[3];

   pmc_debounce #(
      .CYC(DEB_CYC)
   ) u_deb (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_n(reset_n_pin),
      .clean_n_q(btn_n)
   );

   // ------------------------------------------------------------------
   // Wake qualification
   // ------------------------------------------------------------------
   logic sleep_wake;
   logic stop_wake;
   logic sby_wake;

   // Unselected sources are masked off here and never reach the sequencer.
   assign sleep_wake = (|(periph_irq & wake_sel)) | (wake_cfg.trx_en & trx_irq);
   assign stop_wake = (wake_cfg.rtc_en & rtc_s) | (wake_cfg.ext_en & ext_s);
   assign sby_wake = (wake_cfg.rtc_en & rtc_s) | (wake_cfg.pin_en & pin_s);

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   pmc_st_t st_q;
   pmc_st_t st_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic to_boot_q;
   logic to_boot_d;
   logic cnt_zero;

   assign cnt_zero = (cnt_q == '0);

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      to_boot_d = to_boot_q;
      if (!btn_n) begin
         st_d = S_BOOT;
         cnt_d = CNT_W'(BOOT_CYC - 1);
      end else begin
         unique case (st_q)
            S_BOOT: begin
               if (cnt_zero) begin
                  st_d = S_RUN;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            S_RUN: begin
               if (sw.lp_req) begin
                  unique case (sw.lp_target)
                     PMC_SLEEP: st_d = S_SLEEP;
                     PMC_STOP: st_d = S_STOP;
                     PMC_STANDBY: st_d = S_STANDBY;
                     PMC_RUN: st_d = S_RUN;
                  endcase
               end
            end
            S_SLEEP: begin
               if (sleep_wake) begin
                  st_d = S_WAKE;
                  cnt_d = CNT_W'(SLEEP_LAT_CYC - WAKE_PIPE_CYC);
                  to_boot_d = 1'b0;
               end
            end
            S_STOP: begin
               if (stop_wake) begin
                  st_d = S_WAKE;
                  cnt_d = CNT_W'(STOP_LAT_CYC - WAKE_PIPE_CYC);
                  to_boot_d = 1'b0;
               end
            end
            S_STANDBY: begin
               if (sby_wake) begin
                  st_d = S_WAKE;
                  cnt_d = CNT_W'(SBY_CYC - WAKE_PIPE_CYC);
                  to_boot_d = 1'b1;
               end
            end
            S_WAKE: begin
               if (!cnt_zero) begin
                  cnt_d = cnt_q - 1'b1;
               end else if (to_boot_q) begin
                  // Standby lost all context, so wake means a cold start.
                  st_d = S_BOOT;
                  cnt_d = CNT_W'(BOOT_CYC - 1);
               end else begin
                  st_d = S_RUN;
               end
            end
            default: begin
               st_d = S_BOOT;
               cnt_d = CNT_W'(BOOT_CYC - 1);
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= S_BOOT;
         cnt_q <= CNT_W'(BOOT_CYC - 1);
         to_boot_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         to_boot_q <= to_boot_d;
      end
   end

   // ------------------------------------------------------------------
   // Core clock selection and boot source
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         core_clk_sel_q <= CLK_RST;
      end else if (st_d == S_BOOT) begin
         core_clk_sel_q <= CLK_RST;
      end else if (st_q == S_RUN && sw.clk_wr) begin
         core_clk_sel_q <= sw.clk_target;
      end
   end

   // Boot select is caught while the core reset is held, so both a pin
   // reset and a power-on see it; the pad pull-down makes floating read low.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bootloader_q <= 1'b0;
      end else if (st_q == S_BOOT) begin
         bootloader_q <= boot_s;
      end
   end

   // ------------------------------------------------------------------
   // Mode outputs, registered from the next state
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= PMC_RUN;
         core_rst_q <= 1'b1;
         core_clk_en_q <= 1'b1;
         periph_clk_en_q <= '0;
         radio_transceiver_pwr_q <= 1'b0;
         ctx_retain_q <= 1'b0;
         io_hold_q <= 1'b0;
         io_analog_q <= 1'b0;
         main_supply_off_ok_q <= 1'b0;
      end else begin
         core_rst_q <= (st_d == S_BOOT);
         core_clk_en_q <= (st_d == S_BOOT) || (st_d == S_RUN);
         ctx_retain_q <= (st_d != S_STANDBY) && !(st_d == S_WAKE && to_boot_d);
         // Pins stay frozen through the Sleep or Stop wake countdown, until the core runs again; a Standby wake releases them.
         io_hold_q <= (st_d == S_SLEEP) || (st_d == S_STOP) || (st_d == S_WAKE && !to_boot_d);
         io_analog_q <= (st_d == S_STANDBY);
         main_supply_off_ok_q <= (st_d == S_STANDBY);
         unique case (st_d)
            S_RUN: begin
               mode_q <= PMC_RUN;
               periph_clk_en_q <= periph_en | stack_use;
               radio_transceiver_pwr_q <= !sw.trx_off;
            end
            S_SLEEP: begin
               mode_q <= PMC_SLEEP;
               periph_clk_en_q <= wake_sel;
               radio_transceiver_pwr_q <= wake_cfg.trx_en;
            end
            S_STOP: begin
               mode_q <= PMC_STOP;
               periph_clk_en_q <= '0;
               radio_transceiver_pwr_q <= 1'b0;
            end
            S_STANDBY: begin
               mode_q <= PMC_STANDBY;
               periph_clk_en_q <= '0;
               radio_transceiver_pwr_q <= 1'b0;
            end
            S_BOOT: begin
               // A restart shows Run, as a reset does, so no low-power mode is claimed.
               mode_q <= PMC_RUN;
               periph_clk_en_q <= '0;
               radio_transceiver_pwr_q <= 1'b0;
            end
            S_WAKE: begin
               periph_clk_en_q <= '0;
               radio_transceiver_pwr_q <= 1'b0;
            end
            default: begin
               periph_clk_en_q <= '0;
               radio_transceiver_pwr_q <= 1'b0;
            end
         endcase
      end
   end

   // Backup domain sits outside every power switch this block drives.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         backup_keep_q <= 1'b1;
      end else begin
         backup_keep_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic [CNT_W-1:0] sby_wait_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sby_wait_q <= '0;
      end else if (st_q == S_WAKE && to_boot_q) begin
         sby_wait_q <= sby_wait_q + 1'b1;
      end else begin
         sby_wait_q <= '0;
      end
   end

   // The Stop latency is too long for a delay range, so it is counted here.
   logic [CNT_W-1:0] stop_wait_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stop_wait_q <= '0;
      end else if (st_q == S_STOP && stop_wake && btn_n) begin
         stop_wait_q <= CNT_W'(1);
      end else if (stop_wait_q != '0 && !core_clk_en_q) begin
         stop_wait_q <= stop_wait_q + 1'b1;
      end else begin
         stop_wait_q <= '0;
      end
   end

   logic [NPER-1:0] wake_sel_past;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wake_sel_past <= '0;
      end else begin
         wake_sel_past <= wake_sel;
      end
   end

   sequence sleep_wake_s;
      st_q == S_SLEEP && sleep_wake && btn_n;
   endsequence

   sequence clk_back_s;
      core_clk_en_q && mode_q == PMC_RUN;
   endsequence

   boot_to_run_a: assert property ($fell(core_rst_q) |-> core_clk_en_q && mode_q == PMC_RUN
      && core_clk_sel_q == PMC_CLK_8) else $error("reset did not land in run");
   no_self_drop_a: assert property (st_q == S_RUN && !sw.lp_req && btn_n |=> st_q == S_RUN)
      else $error("left run without request");
   run_gating_a: assert property (st_q == S_RUN && st_d == S_RUN |=> periph_clk_en_q ==
      ($past(periph_en) | $past(stack_use)) && radio_transceiver_pwr_q == !$past(sw.trx_off))
      else $error("run clock or radio gating wrong");
   sleep_wake_a: assert property (sleep_wake_s |-> ##[1:450] clk_back_s)
      else $error("sleep wake too slow");
   stop_wake_a: assert property (stop_wait_q <= CNT_W'(STOP_LAT_CYC))
      else $error("stop wake too slow");
   stop_src_a: assert property (st_q == S_STOP && !stop_wake && btn_n |=> st_q == S_STOP)
      else $error("stop left by unselected source");
   lowpwr_gate_a: assert property (mode_q == PMC_STOP |-> !core_clk_en_q && periph_clk_en_q == '0
      && ctx_retain_q && io_hold_q) else $error("stop gating wrong");
   sleep_io_a: assert property (mode_q == PMC_SLEEP |-> io_hold_q && !core_clk_en_q
      && (periph_clk_en_q & ~wake_sel_past) == '0) else $error("sleep state wrong");
   standby_off_a: assert property (st_q == S_STANDBY |-> io_analog_q && !radio_transceiver_pwr_q
      && !ctx_retain_q && main_supply_off_ok_q) else $error("standby state wrong");
   standby_lat_a: assert property (sby_wait_q <= CNT_W'(SBY_CYC))
      else $error("standby wake too slow");
   restart_seq_a: assert property (st_q == S_WAKE && to_boot_q && cnt_zero && btn_n |=> core_rst_q)
      else $error("standby exit skipped reset");
   backup_kept_a: assert property (backup_keep_q) else $error("backup dropped");

endmodule // pmc_power_mode_controller

// File: rtl/pmc_pkg.sv
// Package of the power-mode controller: modes, clock choices, carriers,
// timing constants. Assumes a single 250 MHz system clock.
package pmc_pkg;

   // ------------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ = 250;
   // Wakeup latencies, in ns (1.8 us, 5.4 us, 50 us).
   localparam int SLEEP_LAT_NS = 1800;
   localparam int STOP_LAT_NS = 5400;
   localparam int SBY_LAT_NS = 50000;
   // Longest times round down to whole cycles.
   localparam int SLEEP_LAT_CYC = SLEEP_LAT_NS * CLK_MHZ / 1000;
   localparam int STOP_LAT_CYC = STOP_LAT_NS * CLK_MHZ / 1000;
   localparam int SBY_LAT_CYC = SBY_LAT_NS * CLK_MHZ / 1000;
   // Push-button settling time, in ns; least time rounds up.
   localparam int DEB_NS = 10000;
   localparam int DEB_CYC = (DEB_NS * CLK_MHZ + 999) / 1000;
   // Cycles the core reset is held in the boot sequence.
   localparam int BOOT_CYC = 16;
   // Cycles of a wake spent outside the countdown: synchroniser, counter load and the exit step.
   localparam int WAKE_PIPE_CYC = 4;
   localparam int CNT_W = 16;
   localparam int NPER = 8;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {PMC_RUN, PMC_SLEEP, PMC_STOP, PMC_STANDBY} pmc_mode_t;
   typedef enum logic [1:0] {PMC_CLK_8, PMC_CLK_16, PMC_CLK_32, PMC_CLK_64} pmc_clk_t;
   localparam pmc_clk_t CLK_RST = PMC_CLK_8;

   // Software request strobes and levels, same clock domain.
   typedef struct packed {
      logic lp_req;
      pmc_mode_t lp_target;
      logic trx_off;
      logic clk_wr;
      pmc_clk_t clk_target;
   } pmc_sw_t;

   // Wakeup source selection.
   typedef struct packed {
      logic rtc_en;
      logic ext_en;
      logic pin_en;
      logic trx_en;
   } pmc_wake_t;

endpackage

// File: rtl/pmc_debounce.sv
// Debouncer for an active-low push-button pin.
// Assumes the pin is asynchronous to clk; it is synchronised first.
`timescale 1ns/100ps
module pmc_debounce
   import pmc_pkg::*;
#(
   parameter int CYC = DEB_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pin_n,
   output logic clean_n_q
);

   logic sync1_q;
   logic sync2_q;
   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else begin
         sync1_q <= pin_n;
         sync2_q <= sync1_q;
      end
   end

   // The output only moves after the input has stood still for CYC cycles,
   // so contact bounce never yields more than one reset.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= '0;
         clean_n_q <= 1'b1;
      end else if (sync2_q == clean_n_q) begin
         cnt_q <= '0;
      end else if (cnt_q == CNT_W'(CYC - 1)) begin
         cnt_q <= '0;
         clean_n_q <= sync2_q;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule // pmc_debounce

// File: tb/pmc_wake_model.sv
// Model of the wakeup sources around the power-mode controller: peripheral
// and transceiver interrupts, the RTC event and the two wake pins.
// Assumes the bench calls level() just after a falling clock edge.
`timescale 1ns/100ps
module pmc_wake_model
   import pmc_pkg::*;
(
   output logic rtc_evt,
   output logic ext_irq_pin,
   output logic wakeup_pin,
   output logic trx_irq,
   output logic [NPER-1:0] periph_irq,
   input wire logic main_supply_off_ok_q,
   output logic main_supply_on
);
   // Idle interrupt and pin lines rest low, as their pull-downs leave them.
   initial begin
      rtc_evt = 1'b0;
      ext_irq_pin = 1'b0;
      wakeup_pin = 1'b0;
      trx_irq = 1'b0;
      periph_irq = '0;
   end

   // The main supply is only removed while the device allows it.
   assign main_supply_on = !main_supply_off_ok_q;

   // Source 0 RTC, 1 external pin, 2 wake pin, 3 radio, 4 and up peripherals.
   task automatic level(input int src, input logic v);
      case (src)
         0: rtc_evt = v;
         1: ext_irq_pin = v;
         2: wakeup_pin = v;
         3: trx_irq = v;
         default: periph_irq[src-4] = v;
      endcase
   endtask
endmodule // pmc_wake_model

// File: tb/pmc_power_mode_controller_tb.sv
// Self-checking bench of the power-mode controller with the wake model.
// Assumes a 250 MHz clock; standby latency shortened through SBY_CYC.
`timescale 1ns/100ps
module pmc_power_mode_controller_tb;
   import pmc_pkg::*;
   localparam int SBY = 20;
   logic clk = 1'b0;
   logic sys_rst, reset_n_pin, boot_select_pin, main_supply_on;
   pmc_sw_t sw;
   logic [NPER-1:0] periph_en, stack_use, wake_sel, periph_irq;
   pmc_wake_t wake_cfg;
   logic trx_irq, rtc_evt, ext_irq_pin, wakeup_pin;
   pmc_mode_t mode_q;
   pmc_clk_t core_clk_sel_q;
   logic core_rst_q, core_clk_en_q, radio_transceiver_pwr_q, ctx_retain_q;
   logic io_hold_q, io_analog_q, backup_keep_q, main_supply_off_ok_q, bootloader_q;
   logic [NPER-1:0] periph_clk_en_q;
   int errors = 0;
   int n_compared = 0;

   always #2 clk = ~clk;

   pmc_power_mode_controller #(.SBY_CYC(SBY)) i_pmc_power_mode_controller (.clk(clk), .sys_rst(sys_rst),
      .reset_n_pin(reset_n_pin), .boot_select_pin(boot_select_pin), .sw(sw), .periph_en(periph_en),
      .stack_use(stack_use), .wake_sel(wake_sel), .periph_irq(periph_irq), .wake_cfg(wake_cfg),
      .trx_irq(trx_irq), .rtc_evt(rtc_evt), .ext_irq_pin(ext_irq_pin), .wakeup_pin(wakeup_pin),
      .mode_q(mode_q), .core_rst_q(core_rst_q), .core_clk_en_q(core_clk_en_q),
      .core_clk_sel_q(core_clk_sel_q), .periph_clk_en_q(periph_clk_en_q),
      .radio_transceiver_pwr_q(radio_transceiver_pwr_q), .ctx_retain_q(ctx_retain_q),
      .io_hold_q(io_hold_q), .io_analog_q(io_analog_q), .backup_keep_q(backup_keep_q),
      .main_supply_off_ok_q(main_supply_off_ok_q), .bootloader_q(bootloader_q));

   pmc_wake_model i_pmc_wake_model (.rtc_evt(rtc_evt), .ext_irq_pin(ext_irq_pin), .wakeup_pin(wakeup_pin),
      .trx_irq(trx_irq), .periph_irq(periph_irq), .main_supply_off_ok_q(main_supply_off_ok_q),
      .main_supply_on(main_supply_on));

   // ------------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string w);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, w, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Waits for 0: core reset low, 1: core reset high, 2: core clock on.
   task automatic wait_on(input int which, input int lim, input string w);
      int n;
      // The first falling edge only brings the rising edge that takes the change.
      n = -1;
      while (n <= lim && !((which == 0 && core_rst_q === 1'b0) || (which == 1 && core_rst_q === 1'b1)
             || (which == 2 && core_clk_en_q === 1'b1))) begin
         @(negedge clk);
         n++;
      end
      check(8'(n <= lim), 8'h01, w);
   endtask

   task automatic req(input pmc_mode_t m);
      sw.lp_req = 1'b1;
      sw.lp_target = m;
      @(negedge clk);
      sw.lp_req = 1'b0;
      @(negedge clk);
   endtask

   task automatic run_chk(input string w);
      check(8'(mode_q), 8'(PMC_RUN), w);
      check(8'(core_clk_en_q), 8'h01, w);
      check(periph_clk_en_q, periph_en | stack_use, w);
      check(8'(radio_transceiver_pwr_q), 8'(!sw.trx_off), w);
      check(8'(io_hold_q | io_analog_q), 8'h00, w);
      check(8'(main_supply_off_ok_q), 8'h00, w);
      check(8'(ctx_retain_q), 8'h01, w);
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      reset_n_pin = 1'b1;
      boot_select_pin = 1'b0;
      sw = '0;
      periph_en = '0;
      stack_use = '0;
      wake_sel = '0;
      wake_cfg = '1;
      void'($urandom(32'h2cc0e678));
      repeat (8) @(negedge clk);
      check(8'(core_rst_q), 8'h01, "reset core");
      check(8'(backup_keep_q), 8'h01, "backup");
      check(8'(core_clk_sel_q), 8'(PMC_CLK_8), "clk after reset");
      sys_rst = 1'b0;
      wait_on(0, BOOT_CYC + 2, "boot");
      check(8'(bootloader_q), 8'h00, "no bootloader");
      $display("test reset finished");
      for (int i = 0; i < 8; i++) begin
         periph_en = 8'($urandom);
         stack_use = 8'($urandom) & 8'($urandom);
         sw.trx_off = 1'($urandom);
         sw.clk_wr = 1'b1;
         sw.clk_target = pmc_clk_t'(i % 4);
         @(negedge clk);
         sw.clk_wr = 1'b0;
         repeat (20) @(negedge clk);
         run_chk("run gating");
         check(8'(core_clk_sel_q), 8'(i % 4), "clk select");
      end
      req(PMC_RUN);
      run_chk("run request");
      $display("test run finished");
      for (int s = 4; s >= 3; s--) begin
         wake_sel = (8'($urandom) | 8'h01) & 8'h7f;
         req(PMC_SLEEP);
         check(8'(mode_q), 8'(PMC_SLEEP), "sleep mode");
         check(8'(core_clk_en_q), 8'h00, "sleep core");
         check(periph_clk_en_q, wake_sel, "sleep periph");
         check(8'(radio_transceiver_pwr_q), 8'h01, "sleep radio");
         check(8'(io_hold_q), 8'h01, "sleep pins");
         check(8'(ctx_retain_q & !main_supply_off_ok_q), 8'h01, "sleep context");
         i_pmc_wake_model.level(11, 1'b1);
         repeat (500) @(negedge clk);
         check(8'(core_clk_en_q), 8'h00, "unselected irq");
         i_pmc_wake_model.level(11, 1'b0);
         i_pmc_wake_model.level(s, 1'b1);
         wait_on(2, SLEEP_LAT_CYC, "sleep wake");
         i_pmc_wake_model.level(s, 1'b0);
         @(negedge clk);
         run_chk("after sleep");
      end
      $display("test sleep finished");
      for (int s = 0; s < 2; s++) begin
         req(PMC_STOP);
         check(8'(mode_q), 8'(PMC_STOP), "stop mode");
         check(periph_clk_en_q | 8'(core_clk_en_q), 8'h00, "stop clocks");
         check(8'(io_hold_q & ctx_retain_q), 8'h01, "stop hold");
         check(8'(main_supply_off_ok_q), 8'h00, "stop supply");
         check(8'(main_supply_on), 8'h01, "stop main supply");
         // The right source, but with its enable off, must not wake either.
         wake_cfg = (s == 0) ? 4'h7 : 4'hb;
         i_pmc_wake_model.level(2, 1'b1);
         i_pmc_wake_model.level(4, 1'b1);
         i_pmc_wake_model.level(s, 1'b1);
         repeat (1400) @(negedge clk);
         check(8'(core_clk_en_q), 8'h00, "stop other source");
         i_pmc_wake_model.level(2, 1'b0);
         i_pmc_wake_model.level(4, 1'b0);
         i_pmc_wake_model.level(s, 1'b0);
         repeat (4) @(negedge clk);
         wake_cfg = '1;
         i_pmc_wake_model.level(s, 1'b1);
         wait_on(2, STOP_LAT_CYC, "stop wake");
         i_pmc_wake_model.level(s, 1'b0);
         @(negedge clk);
         run_chk("after stop");
      end
      $display("test stop finished");
      for (int s = 2; s >= 0; s -= 2) begin
         boot_select_pin = (s == 2);
         sw.clk_wr = 1'b1;
         sw.clk_target = PMC_CLK_64;
         @(negedge clk);
         sw.clk_wr = 1'b0;
         req(PMC_STANDBY);
         check(8'(radio_transceiver_pwr_q) | periph_clk_en_q, 8'h00, "standby off");
         check(8'(ctx_retain_q), 8'h00, "standby context");
         check(8'(io_analog_q), 8'h01, "standby pins");
         check(8'(main_supply_off_ok_q & backup_keep_q), 8'h01, "standby supply");
         check(8'(main_supply_on), 8'h00, "standby main supply");
         i_pmc_wake_model.level(1, 1'b1);
         repeat (100) @(negedge clk);
         check(8'(core_clk_en_q | core_rst_q), 8'h00, "standby other source");
         i_pmc_wake_model.level(1, 1'b0);
         i_pmc_wake_model.level(s, 1'b1);
         wait_on(1, SBY, "standby wake");
         i_pmc_wake_model.level(s, 1'b0);
         wait_on(0, BOOT_CYC + 2, "standby restart");
         check(8'(bootloader_q), 8'(s == 2), "boot select");
         check(8'(core_clk_sel_q), 8'(PMC_CLK_8), "restart clk");
         run_chk("after standby");
      end
      boot_select_pin = 1'b0;
      $display("test standby finished");
      // A short press must not reset; a long one must, once.
      reset_n_pin = 1'b0;
      repeat (100) @(negedge clk);
      reset_n_pin = 1'b1;
      repeat (2700) @(negedge clk);
      check(8'(core_rst_q), 8'h00, "glitch ignored");
      reset_n_pin = 1'b0;
      repeat (DEB_CYC + 20) @(negedge clk);
      check(8'(core_rst_q), 8'h01, "press resets");
      reset_n_pin = 1'b1;
      wait_on(0, DEB_CYC + BOOT_CYC + 8, "press release");
      run_chk("after press");
      $display("test debounce finished");
      conclude();
   end

   initial begin
      #(4 * 40000);
      errors++;
      conclude();
   end
endmodule // pmc_power_mode_controller_tb
